// file: src/gate_ctl_pkg.sv
// Constants for the gate driver serial port and fault control core
package gate_ctl_pkg;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          WORD_BITS       = 16;
    localparam int          CMD_BITS        = 5;
    localparam int          DATA_BITS       = 11;
    localparam int          ADDR_BITS       = 4;
    localparam int          RW_POS          = 15;
    localparam int          ADDR_HI         = 14;
    localparam int          ADDR_LO         = 11;
    localparam int          NUM_REGS        = 16;
    localparam logic [4:0]  BIT_CNT_FULL    = 5'h10;
    localparam logic [4:0]  BIT_CNT_ZERO    = 5'h00;
    localparam logic [4:0]  BIT_CNT_SAT     = 5'h1f;
    localparam logic        CMD_WRITE       = 1'b0;
    // Register indices used by the fault logic
    localparam logic [3:0]  REG_STATUS      = 4'h0;
    localparam logic [3:0]  REG_CONTROL     = 4'h2;
    localparam logic [3:0]  REG_PROTECT     = 4'h5;
    // Field positions in the control registers
    localparam int          CLEAR_POS       = 0;
    localparam int          WARN_REP_POS    = 1;
    localparam int          DISABLE_GATE_DRIVE_FAULT_POS     = 2;
    localparam int          DISABLE_DRIVE_SUPPLY_UV_POS    = 3;
    localparam int          DIS_SHUNT_POS   = 4;
    localparam int          MODE_LO         = 6;
    localparam int          MODE_HI         = 7;
    localparam logic [10:0] REG_RESET       = 11'h000;
    // Status field positions
    localparam int          ST_FAULT        = 10;
    localparam int          ST_VDS          = 9;
    localparam int          ST_GDF          = 8;
    localparam int          ST_UV           = 7;
    localparam int          ST_TSD          = 6;
    localparam int          ST_SEN          = 5;
    localparam int          ST_OTW          = 4;
    localparam int          ST_DRV_UV       = 3;
    // Overcurrent response modes
    localparam logic [1:0]  OCP_LATCH       = 2'h0;
    localparam logic [1:0]  OCP_RETRY       = 2'h1;
    localparam logic [1:0]  OCP_REPORT      = 2'h2;
    localparam logic [1:0]  OCP_OFF         = 2'h3;
    // Times in microseconds, cycles derived from the clock rate
    localparam int          RETRY_US        = 8000;
    localparam int          DRIVE_US        = 4;
    localparam int          SLEEP_US        = 100;
    localparam int          WAKE_US         = 1000;
    localparam int          RST_WIN_US      = 20;
    localparam int          RETRY_CYC       = RETRY_US * (CLK_HZ / 1_000_000);
    localparam int          DRIVE_CYC       = DRIVE_US * (CLK_HZ / 1_000_000);
    localparam int          SLEEP_CYC       = SLEEP_US * (CLK_HZ / 1_000_000);
    localparam int          WAKE_CYC        = WAKE_US * (CLK_HZ / 1_000_000);
    localparam int          RST_WIN_CYC     = RST_WIN_US * (CLK_HZ / 1_000_000);
    localparam int          CNT_W           = 20;
endpackage

// file: src/gate_ctl_core.sv
// Serial register port, fault response and enable sequencing of a gate driver
// Behaviour
// - Input word is 16 bits: 5 command bits then 11 data bits.
// - Output word: upper 5 bits don't care, lower 11 register data.
// - Chip select high: ignore clock and data, data-out released.
// - Sample on falling clock edge, launch on rising, MSB first.
// - Frame without exactly 16 clocks is a frame error and discarded.
// - Write returns the register's previous contents after command bits.
// - Data-out is open drain: pull low or release.
// - Bit 15 read/write, bits 14..11 address, 10..0 data.
// - Response data is the addressed register's current value.
// - Supply or drain undervoltage: report, gates Hi-Z, automatic recovery.
// - Drive supply undervoltage: report and Hi-Z unless disable bit set.
// - Overcurrent mode: latch, retry, report only, or nothing.
// - Stuck gate past drive timeout: report, Hi-Z, latch unless disabled.
// - Thermal warning keeps gates active, on the indicator only when enabled.
// - Thermal shutdown: report, Hi-Z, automatic recovery.
// - Enable low means sleep: everything off, registers to defaults.
// - Wait sleep delay after enable falls before sleeping.
// - Enable high leaves sleep; inputs accepted after wake delay.
// - Latched faults hold until condition gone and clear bit or pulse.
// - Short enable low pulse clears faults without disturbing settings.
// - Warning report bit routes warning to indicator and summary bit.
`timescale 1ns/1ps
`default_nettype none
module gate_ctl_core
    import gate_ctl_pkg::*;
#(
    parameter int RETRY_CYCLES = gate_ctl_pkg::RETRY_CYC,
    parameter int WAKE_CYCLES  = gate_ctl_pkg::WAKE_CYC
) (
    input  wire logic CLK_I,
    input  wire logic RST_I,
    input  wire logic CHIP_SELECT_N_I,
    input  wire logic SCLK_I,
    input  wire logic SDI_I,
    output logic      SDO_O,
    output logic      SDO_OE_O,
    input  wire logic ENABLE_I,
    input  wire logic SUPPLY_UNDERVOLTAGE_I,
    input  wire logic DRAIN_SUPPLY_UNDERVOLTAGE_I,
    input  wire logic CHARGE_PUMP_UNDERVOLTAGE_I,
    input  wire logic LOWSIDE_REGULATOR_UNDERVOLTAGE_I,
    input  wire logic DRAIN_SOURCE_OVERCURRENT_I,
    input  wire logic SHUNT_OVERCURRENT_I,
    input  wire logic GATE_STUCK_I,
    input  wire logic THERMAL_WARNING_I,
    input  wire logic THERMAL_SHUTDOWN_I,
    output logic      FAULT_INDICATOR_N_O,
    output logic      GATES_HIZ_O,
    output logic      AWAKE_O,
    output logic      READY_O,
    output logic      FRAME_ERROR_O
);
    import gate_ctl_pkg::*;

    typedef enum logic [1:0] {
        ST_SLEEP   = 2'b00,
        ST_WAKING  = 2'b01,
        ST_RUN     = 2'b10,
        ST_LOW_ENA = 2'b11
    } power_e;

    power_e power_state;
    logic [CNT_W-1:0] pwr_cnt;
    logic [2:0] cs_sync, sclk_sync, ena_sync;
    logic [1:0] sdi_sync; // Data needs no edge stage
    logic [10:0] regs [NUM_REGS];
    logic [WORD_BITS-1:0] shift_in;
    logic [DATA_BITS-1:0] shift_out;
    logic [4:0] bit_cnt;
    logic latch_vds, latch_sen, latch_gdf, sticky_tsd;
    logic retry_busy;
    logic [CNT_W-1:0] retry_cnt, stuck_cnt;
    logic clear_req, ena_pulse;
    logic sleeping;
    // Live status word; read at the fifth clock fall of a status access
    logic [10:0] status_word;

    // Address field of a whole received word, for the write and the clear
    function automatic logic [ADDR_BITS-1:0] word_addr(input logic [WORD_BITS-1:0] w);
        return w[ADDR_HI:ADDR_LO];
    endfunction

    // Two flops before use; stage 3 feeds edge detection only
    // Fault inputs share this clock and are read without these stages
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cs_sync   <= 3'h7;
            sclk_sync <= 3'h0;
            sdi_sync  <= 2'h0;
            ena_sync  <= 3'h0;
        end else begin
            cs_sync   <= {cs_sync[1:0], CHIP_SELECT_N_I};
            sclk_sync <= {sclk_sync[1:0], SCLK_I};
            sdi_sync  <= {sdi_sync[0], SDI_I};
            ena_sync  <= {ena_sync[1:0], ENABLE_I};
        end
    end

    wire logic cs_active = ~cs_sync[1];
    wire logic cs_rise   = cs_sync[1] & ~cs_sync[2];
    wire logic sclk_fall = ~sclk_sync[1] & sclk_sync[2];
    wire logic sclk_rise = sclk_sync[1] & ~sclk_sync[2];
    wire logic ena_now   = ena_sync[1];
    assign sleeping = (power_state == ST_SLEEP);
    // At the fall that completes the address its last bit is still in the
    // synchroniser, not yet in the shift register
    wire logic [ADDR_BITS-1:0] addr_now = {shift_in[ADDR_BITS-2:0], sdi_sync[1]};

    // Enable sequencing: sleep delay, wake delay, reset pulse window.
    // Low enable in run keeps settings until the sleep delay runs out, so a
    // short low can act as a fault clear pulse without touching registers.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            power_state <= ST_SLEEP;
            pwr_cnt     <= '0;
            ena_pulse   <= 1'b0;
        end else begin
            ena_pulse <= 1'b0;
            unique case (power_state)
                ST_SLEEP: begin
                    pwr_cnt <= '0;
                    if (ena_now) begin
                        power_state <= ST_WAKING;
                    end
                end
                ST_WAKING: begin
                    if (!ena_now) begin
                        // Nothing is configured yet, so an early drop sleeps at once
                        power_state <= ST_SLEEP;
                    end else if (pwr_cnt >= CNT_W'(WAKE_CYCLES - 1)) begin
                        power_state <= ST_RUN;
                        pwr_cnt     <= '0;
                    end else begin
                        pwr_cnt <= pwr_cnt + 1'b1;
                    end
                end
                ST_RUN: begin
                    pwr_cnt <= '0;
                    if (!ena_now) begin
                        power_state <= ST_LOW_ENA;
                    end
                end
                ST_LOW_ENA: begin
                    if (ena_now) begin
                        // Short low is a fault clear pulse only
                        power_state <= ST_RUN;
                        ena_pulse   <= (pwr_cnt < CNT_W'(RST_WIN_CYC));
                        pwr_cnt     <= '0;
                    end else if (pwr_cnt >= CNT_W'(SLEEP_CYC - 1)) begin
                        // Low past the window and the delay: full shutdown
                        power_state <= ST_SLEEP;
                    end else begin
                        pwr_cnt <= pwr_cnt + 1'b1;
                    end
                end
            endcase
        end
    end

    wire logic port_on = (power_state == ST_RUN) || (power_state == ST_LOW_ENA);

    // Serial receive, frame check, register access
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            shift_in      <= '0;
            shift_out     <= '0;
            bit_cnt       <= BIT_CNT_ZERO;
            FRAME_ERROR_O <= 1'b0;
            clear_req     <= 1'b0;
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else begin
            clear_req <= 1'b0;
            if (sleeping) begin
                bit_cnt <= BIT_CNT_ZERO;
                for (int i = 0; i < NUM_REGS; i++) begin
                    regs[i] <= REG_RESET;
                end
            end else if (!port_on || !cs_active) begin
                bit_cnt <= BIT_CNT_ZERO;
                if (cs_rise && port_on) begin
                    if (bit_cnt != BIT_CNT_FULL) begin
                        FRAME_ERROR_O <= 1'b1;
                    end else begin
                        FRAME_ERROR_O <= 1'b0;
                        // Status is read only, so a write to it is dropped
                        if (shift_in[RW_POS] == CMD_WRITE
                            && word_addr(shift_in) != REG_STATUS) begin
                            regs[word_addr(shift_in)] <= shift_in[DATA_BITS-1:0];
                            clear_req <= (word_addr(shift_in) == REG_CONTROL)
                                         && shift_in[CLEAR_POS];
                        end
                    end
                end
            end else if (sclk_fall) begin
                shift_in <= {shift_in[WORD_BITS-2:0], sdi_sync[1]};
                if (bit_cnt != BIT_CNT_SAT) begin
                    bit_cnt <= bit_cnt + 1'b1;
                end
                // Address known after command bits; load old contents
                if (bit_cnt == 5'(CMD_BITS - 1)) begin
                    shift_out <= (addr_now == REG_STATUS)
                                 ? status_word
                                 : regs[addr_now];
                end
            end else if (sclk_rise && bit_cnt > 5'(CMD_BITS)) begin
                shift_out <= {shift_out[DATA_BITS-2:0], 1'b0};
            end
            if (regs[REG_CONTROL][CLEAR_POS]) begin
                regs[REG_CONTROL][CLEAR_POS] <= 1'b0; // Self clearing
            end
        end
    end

    // Configuration fields and qualified fault conditions. Fault inputs are
    // already on this clock, so they are used without synchronisers.
    wire logic [1:0] overcurrent_response_mode   = regs[REG_CONTROL][MODE_HI:MODE_LO];
    wire logic warn_rep         = regs[REG_CONTROL][WARN_REP_POS];
    wire logic disable_gate_drive_fault          = regs[REG_PROTECT][DISABLE_GATE_DRIVE_FAULT_POS];
    wire logic disable_drive_supply_uv         = regs[REG_PROTECT][DISABLE_DRIVE_SUPPLY_UV_POS];
    wire logic dis_shunt        = regs[REG_PROTECT][DIS_SHUNT_POS];
    wire logic clear_any        = clear_req | ena_pulse;
    wire logic vds_now          = DRAIN_SOURCE_OVERCURRENT_I && overcurrent_response_mode != OCP_OFF;
    wire logic sen_now          = SHUNT_OVERCURRENT_I && overcurrent_response_mode != OCP_OFF && !dis_shunt;
    wire logic drv_uv           = (CHARGE_PUMP_UNDERVOLTAGE_I
                                   | LOWSIDE_REGULATOR_UNDERVOLTAGE_I) & ~disable_drive_supply_uv;
    wire logic main_uv          = SUPPLY_UNDERVOLTAGE_I | DRAIN_SUPPLY_UNDERVOLTAGE_I;
    wire logic gdf_now          = (stuck_cnt >= CNT_W'(DRIVE_CYC)) && !disable_gate_drive_fault;
    wire logic warn_shown       = THERMAL_WARNING_I & warn_rep;

    // Stuck gate timer; saturates at the timeout so the fault keeps
    // asserting for as long as the gate stays stuck
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            stuck_cnt <= '0;
        end else if (!GATE_STUCK_I) begin
            stuck_cnt <= '0;
        end else if (stuck_cnt < CNT_W'(DRIVE_CYC)) begin
            stuck_cnt <= stuck_cnt + 1'b1;
        end
    end

    // Latched faults; a new event wins over a clear in the same cycle
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            latch_vds  <= 1'b0;
            latch_sen  <= 1'b0;
            latch_gdf  <= 1'b0;
            sticky_tsd <= 1'b0;
        end else if (sleeping) begin
            latch_vds  <= 1'b0;
            latch_sen  <= 1'b0;
            latch_gdf  <= 1'b0;
            sticky_tsd <= 1'b0;
        end else begin
            if (vds_now && overcurrent_response_mode != OCP_RETRY) begin
                latch_vds <= 1'b1;
            end else if (clear_any) begin
                latch_vds <= 1'b0;
            end
            if (sen_now && overcurrent_response_mode != OCP_RETRY) begin
                latch_sen <= 1'b1;
            end else if (clear_any) begin
                latch_sen <= 1'b0;
            end
            if (gdf_now) begin
                latch_gdf <= 1'b1;
            end else if (clear_any) begin
                latch_gdf <= 1'b0;
            end
            if (THERMAL_SHUTDOWN_I) begin
                sticky_tsd <= 1'b1;
            end else if (clear_any) begin
                sticky_tsd <= 1'b0;
            end
        end
    end

    // Retry timer for overcurrent retry mode
    // Restarts on every event, so the gates stay off a full period after the last
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            retry_busy <= 1'b0;
            retry_cnt  <= '0;
        end else if (sleeping) begin
            retry_busy <= 1'b0;
            retry_cnt  <= '0;
        end else if ((vds_now || sen_now) && overcurrent_response_mode == OCP_RETRY) begin
            retry_busy <= 1'b1;
            retry_cnt  <= '0;
        end else if (retry_busy) begin
            if (retry_cnt >= CNT_W'(RETRY_CYCLES - 1)) begin
                retry_busy <= 1'b0;
            end else begin
                retry_cnt <= retry_cnt + 1'b1;
            end
        end
    end

    // Gate and report decisions; report-only overcurrent keeps the gates active
    wire logic ocp_latched = (latch_vds | latch_sen) & (overcurrent_response_mode == OCP_LATCH
                             | overcurrent_response_mode == OCP_REPORT);
    wire logic hiz_now = main_uv | drv_uv | THERMAL_SHUTDOWN_I | latch_gdf | retry_busy
                         | ((latch_vds | latch_sen) & overcurrent_response_mode == OCP_LATCH);
    wire logic report_now = main_uv | drv_uv | THERMAL_SHUTDOWN_I | latch_gdf | retry_busy
                            | ocp_latched | warn_shown;
    // Status fields read back at address zero
    assign status_word = (11'(report_now) << ST_FAULT) | (11'(latch_vds) << ST_VDS)
                       | (11'(latch_gdf) << ST_GDF) | (11'(main_uv) << ST_UV)
                       | (11'(sticky_tsd) << ST_TSD) | (11'(latch_sen) << ST_SEN)
                       | (11'(THERMAL_WARNING_I) << ST_OTW) | (11'(drv_uv) << ST_DRV_UV);

    // Registered outputs
    // Indicator released and gates off while asleep, whatever the inputs do
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            FAULT_INDICATOR_N_O <= 1'b1;
            GATES_HIZ_O         <= 1'b1;
            AWAKE_O             <= 1'b0;
            READY_O             <= 1'b0;
            SDO_O               <= 1'b0;
            SDO_OE_O            <= 1'b0;
        end else begin
            FAULT_INDICATOR_N_O <= sleeping | ~report_now;
            GATES_HIZ_O         <= sleeping | hiz_now;
            AWAKE_O             <= ~sleeping;
            READY_O             <= port_on;
            SDO_O               <= 1'b0;
            // Pull low only for a zero data bit; pull-up gives ones
            SDO_OE_O            <= port_on && cs_active && bit_cnt >= 5'(CMD_BITS)
                                   && bit_cnt < BIT_CNT_FULL
                                   && !shift_out[DATA_BITS-1];
        end
    end
endmodule
`default_nettype wire

// file: verification/gate_ctl_chk.sv
// Port-level assertion checker for the gate driver control core
`timescale 1ns/1ps
`default_nettype none
module gate_ctl_chk
    import gate_ctl_pkg::*;
#(
    parameter int WAKE_CYCLES = 20
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic CHIP_SELECT_N_I,
    input wire logic ENABLE_I,
    input wire logic SUPPLY_UNDERVOLTAGE_I,
    input wire logic THERMAL_SHUTDOWN_I,
    input wire logic SDO_O,
    input wire logic SDO_OE_O,
    input wire logic FAULT_INDICATOR_N_O,
    input wire logic GATES_HIZ_O,
    input wire logic AWAKE_O,
    input wire logic READY_O
);
    // Margin covers the enable synchroniser
    localparam int SLP_LIM = SLEEP_CYC + 8;
    logic [11:0] lo_cnt;
    logic [11:0] aw_cnt;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Run length of enable low, saturating
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) lo_cnt <= 12'h000;
        else lo_cnt <= ENABLE_I ? 12'h000 : lo_cnt + 12'(lo_cnt != 12'hfff);
    end
    // Run length of being awake, saturating
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) aw_cnt <= 12'h000;
        else aw_cnt <= AWAKE_O ? aw_cnt + 12'(aw_cnt != 12'hfff) : 12'h000;
    end
    AST_SDO_LOW: assert property (!SDO_O)
        else $error("data out driven high");
    AST_CS_IDLE: assert property (CHIP_SELECT_N_I [*6] |-> !SDO_OE_O)
        else $error("data out pulled low while deselected");
    AST_UV_HIZ: assert property (
        $rose(SUPPLY_UNDERVOLTAGE_I) && AWAKE_O |-> ##[1:3] (GATES_HIZ_O && !FAULT_INDICATOR_N_O))
        else $error("supply undervoltage not acted on");
    AST_TSD_HIZ: assert property (
        $rose(THERMAL_SHUTDOWN_I) && AWAKE_O |-> ##[1:3] (GATES_HIZ_O && !FAULT_INDICATOR_N_O))
        else $error("thermal shutdown not acted on");
    AST_SLEEP_HIZ: assert property (!AWAKE_O [*2] |-> GATES_HIZ_O)
        else $error("gates active while asleep");
    AST_SLEEP_HOLD: assert property ($fell(ENABLE_I) && AWAKE_O |-> AWAKE_O [*8])
        else $error("slept without the sleep delay");
    AST_SLEEP_ENTER: assert property (lo_cnt == 12'(SLP_LIM) |-> !AWAKE_O)
        else $error("still awake after long enable low");
    AST_READY_EARLY: assert property ($rose(READY_O) |-> aw_cnt >= 12'(WAKE_CYCLES - 2))
        else $error("ready before the wake delay");
    AST_READY_LATE: assert property (aw_cnt == 12'(WAKE_CYCLES + 6) && ENABLE_I |-> READY_O)
        else $error("not ready after the wake delay");
endmodule
bind gate_ctl_core gate_ctl_chk #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (
    .CLK_I(CLK_I), .RST_I(RST_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I), .ENABLE_I(ENABLE_I),
    .SUPPLY_UNDERVOLTAGE_I(SUPPLY_UNDERVOLTAGE_I), .THERMAL_SHUTDOWN_I(THERMAL_SHUTDOWN_I),
    .SDO_O(SDO_O), .SDO_OE_O(SDO_OE_O), .FAULT_INDICATOR_N_O(FAULT_INDICATOR_N_O),
    .GATES_HIZ_O(GATES_HIZ_O), .AWAKE_O(AWAKE_O), .READY_O(READY_O)
);
`default_nettype wire

// file: verification/spi_master_model.sv
// Serial port master model standing in for the motor controller
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      sdi_o
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o  = 1'b0;
    end
    // One frame of n clocks; 800 ns serial clock, four system cycles per phase
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
        r = 16'h0000;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            sclk_o = 1'b1;
            sdi_o  = w[4'hf - 4'(i)];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            r      = {r[14:0], sdo_i};
            repeat (4) @(negedge clk_i);
        end
        cs_n_o = 1'b1;
        sdi_o  = ~sdi_o; // Stale line must not look held
        repeat (8) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: verification/gate_ctl_core_tb.sv
// Self-checking bench for the gate driver control core
`timescale 1ns/1ps
`default_nettype none
module gate_ctl_core_tb;
    import gate_ctl_pkg::*;
    localparam int RETRY_N = 50;
    localparam int WAKE_N  = 20;
    logic        clk, rst, enable, cs_n, sclk, sdi;
    logic        sdo, sdo_oe, flt_n, hiz, awake, ready, frame_err;
    logic [8:0]  flt;
    logic [10:0] mdl [16];
    logic [31:0] seed;
    logic [15:0] r;
    logic [2:0]  e;
    wire         sdo_line;
    int          n;
    int          err_total;
    int          checks;
    // Open-drain line with pull-up
    assign sdo_line = sdo_oe ? sdo : 1'b1;
    gate_ctl_core #(.RETRY_CYCLES(RETRY_N), .WAKE_CYCLES(WAKE_N)) dut_u (
        .CLK_I(clk), .RST_I(rst), .CHIP_SELECT_N_I(cs_n), .SCLK_I(sclk), .SDI_I(sdi),
        .SDO_O(sdo), .SDO_OE_O(sdo_oe), .ENABLE_I(enable),
        .SUPPLY_UNDERVOLTAGE_I(flt[0]), .DRAIN_SUPPLY_UNDERVOLTAGE_I(flt[1]),
        .CHARGE_PUMP_UNDERVOLTAGE_I(flt[2]), .LOWSIDE_REGULATOR_UNDERVOLTAGE_I(flt[3]),
        .THERMAL_SHUTDOWN_I(flt[4]), .THERMAL_WARNING_I(flt[5]), .GATE_STUCK_I(flt[6]),
        .SHUNT_OVERCURRENT_I(flt[7]), .DRAIN_SOURCE_OVERCURRENT_I(flt[8]),
        .FAULT_INDICATOR_N_O(flt_n), .GATES_HIZ_O(hiz), .AWAKE_O(awake), .READY_O(ready),
        .FRAME_ERROR_O(frame_err)
    );
    spi_master_model spi_u (
        .clk_i(clk), .sdo_i(sdo_line), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi)
    );
    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Expected {hiz, report, still held after removal} per fault input
    function automatic logic [2:0] expect_of(input int k, input logic dis);
        case (k)
            2, 3: return dis ? 3'h0 : 3'h6;
            5: return {1'b0, dis, 1'b0};
            6, 7: return dis ? 3'h0 : 3'h7;
            default: return 3'h6;
        endcase
    endfunction
    function automatic logic [15:0] pins();
        return {14'h0000, hiz, flt_n};
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [10:0] d);
        logic [15:0] q;
        spi_u.xfer({CMD_WRITE, a, d}, 16, q);
        chk("prev", 16'(q[10:0]), 16'(mdl[a]));
        if (a != REG_STATUS) mdl[a] = (a == REG_CONTROL) ? (d & 11'h7fe) : d;
    endtask
    task automatic rd(input logic [3:0] a);
        logic [15:0] q;
        spi_u.xfer({1'b1, a, 11'h000}, 16, q);
        chk("read", 16'(q[10:0]), 16'(mdl[a]));
    endtask
    task automatic clear_flt;
        wr(REG_CONTROL, mdl[REG_CONTROL] | 11'h001);
        repeat (4) @(negedge clk);
    endtask
    task automatic wait_ready(output int c);
        c = 0;
        while (ready !== 1'b1 && c < 1000) begin
            @(negedge clk);
            c++;
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        #5_000_000;
        err_total++;
        tally_and_finish;
    end
    initial begin
        rst = 1'b1;
        enable = 1'b1;
        flt = 9'h000;
        seed = 32'h0000_179b;
        err_total = 0;
        checks = 0;
        foreach (mdl[i]) mdl[i] = 11'h000;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        wait_ready(n);
        chk("wake", 16'(n >= WAKE_N && n <= WAKE_N + 8), 16'h0001);
        // Two passes so each second-pass write returns the first-pass random value, status and the control clear bit excepted
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 16; a++) begin
                seed = lfsr(seed);
                wr(4'(a), seed[10:0]);
                rd(4'(a));
            end
        end
        // Short and long frames are discarded
        for (int nb = 15; nb <= 17; nb += 2) begin
            seed = lfsr(seed);
            spi_u.xfer({CMD_WRITE, 4'h3, seed[10:0]}, nb, r);
            chk("ferr", 16'(frame_err), 16'h0001);
            rd(4'h3);
            chk("ferr_ok", 16'(frame_err), 16'h0000);
        end
        // Fault table with detection enabled, then disabled and warning reported
        for (int d = 0; d < 2; d++) begin
            wr(REG_PROTECT, d ? 11'h01c : 11'h000);
            wr(REG_CONTROL, d ? 11'h002 : 11'h000);
            for (int k = 0; k < 8; k++) begin
                e = expect_of(k, d[0]);
                flt[k] = 1'b1;
                repeat (60) @(negedge clk);
                chk("on", pins(), {14'h0000, e[2], !e[1]});
                spi_u.xfer({1'b1, REG_STATUS, 11'h000}, 16, r);
                chk("summary", 16'(r[ST_FAULT]), 16'(e[1]));
                chk("st_uv", 16'(r[ST_UV]), 16'(k < 2));
                chk("st_otw", 16'(r[ST_OTW]), 16'(k == 5));
                flt[k] = 1'b0;
                repeat (5) @(negedge clk);
                chk("off", pins(), {14'h0000, e[0], !e[0]});
                clear_flt;
                chk("clr", pins(), 16'h0001);
            end
        end
        // Every overcurrent response mode
        for (int m = 0; m < 4; m++) begin
            wr(REG_CONTROL, 11'(m << 6));
            flt[8] = 1'b1;
            repeat (5) @(negedge clk);
            flt[8] = 1'b0;
            repeat (5) @(negedge clk);
            chk("oc", pins(), 16'({m < 2, m == 3}));
            repeat (RETRY_N + 10) @(negedge clk);
            chk("oc_late", pins(), 16'({m == 0, m[0]}));
            clear_flt;
            chk("oc_clr", pins(), 16'h0001);
        end
        // Enable pulse clears a latch and keeps settings
        wr(4'h4, 11'h2a5);
        wr(REG_CONTROL, 11'h000);
        flt[8] = 1'b1;
        repeat (5) @(negedge clk);
        flt[8] = 1'b0;
        repeat (5) @(negedge clk);
        chk("latch", pins(), 16'h0002);
        enable = 1'b0;
        repeat (50) @(negedge clk);
        enable = 1'b1;
        repeat (10) @(negedge clk);
        chk("pulse", 16'({awake, hiz, flt_n}), 16'h0005);
        rd(4'h4);
        // Long enable low sleeps and resets the registers
        enable = 1'b0;
        repeat (SLEEP_CYC / 2) @(negedge clk);
        chk("pre_sleep", 16'(awake), 16'h0001);
        repeat (SLEEP_CYC / 2 + 20) @(negedge clk);
        chk("sleep", 16'({awake, hiz}), 16'h0001);
        enable = 1'b1;
        wait_ready(n);
        chk("rewake", 16'(n >= WAKE_N && n <= WAKE_N + 8), 16'h0001);
        foreach (mdl[i]) mdl[i] = 11'h000;
        rd(4'h4);
        tally_and_finish;
    end
endmodule
`default_nettype wire
